// file: verilog/quad_bank_sdram_core.sv
// sdram access core: command decode, bursts, data array, masks
`include "qbs_regs.svh"
// Overview of operation
// - sample all inputs but resetn on rising mclk; resetn clears asynchronously
// - four banks, two-bit bank field
// - activate latches bank and twelve-bit row
// - read/write address gives start column
// - burst lengths 1,2,4,8,page; terminate
// - internal column counter continues burst
// - auto precharge starts at burst end
// - new column command on any cycle
// - precharge one bank while accessing others
// - chip select high ignores new commands
// - mask blocks writes, read high-z two clocks
// - precharge scope bit: auto/all banks
module quad_bank_sdram_core (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankSel,
  input wire logic [11:0] addr,
  input wire logic [3:0] byteMask,
  input wire logic [2:0] burst_length,
  input wire logic [31:0] dqIn,
  output logic [31:0] dqOut,
  output logic [3:0] dqOe
);
  localparam int DEPTH = 256;
  typedef struct packed {
    logic busy;
    logic isWrite;
    logic [1:0] bank;
    logic [7:0] col;
    logic [8:0] left;
    logic [2:0] blen;
    logic rdV1;
    logic [3:0] mask1;
    logic [3:0] oe;
    logic [31:0] dout;
    logic [31:0] rdD1;
  } qbs_core_s;
  qbs_core_s r, next_r;
  logic [31:0] mem [0:4*DEPTH-1];
  qbs_pkg::qbs_cmd_e cmd;
  logic [3:0] actV, preV, apV, endV, openV;
  logic wrEn;
  logic [9:0] wrIdx;
  function automatic logic [8:0] burst_count(input logic [2:0] bl);
    case (bl)
      3'h0: burst_count = 9'h001;
      3'h1: burst_count = 9'h002;
      3'h2: burst_count = 9'h004;
      3'h3: burst_count = 9'h008;
      `QBS_FULL_PAGE: burst_count = 9'h100;
      default: burst_count = 9'h001;
    endcase
  endfunction
  function automatic logic [7:0] next_col(input logic [7:0] c, input logic [2:0] bl);
    logic [7:0] m;
    m = 8'(burst_count(bl) - 9'h001);
    next_col = (c & ~m) | ((c + 8'h01) & m);
  endfunction
  always_comb begin
    cmd = qbs_pkg::QBS_NOP;
    if (!csN) begin
      case ({rasN, casN, weN})
        3'b011: cmd = qbs_pkg::QBS_ACT;
        3'b101: cmd = qbs_pkg::QBS_RD;
        3'b100: cmd = qbs_pkg::QBS_WR;
        3'b010: cmd = qbs_pkg::QBS_PRE;
        3'b110: cmd = qbs_pkg::QBS_BST;
        3'b000: cmd = qbs_pkg::QBS_LMR;
        3'b001: cmd = qbs_pkg::QBS_REF;
        default: cmd = qbs_pkg::QBS_NOP;
      endcase
    end
  end
  qbs_bank_if bif [`QBS_BANKS] ();
  genvar g;
  generate
    for (g = 0; g < `QBS_BANKS; g++) begin : gBank
      assign bif[g].act = actV[g];
      assign bif[g].pre = preV[g];
      assign bif[g].autoPre = apV[g];
      assign bif[g].burstEnd = endV[g];
      assign bif[g].row = addr;
      assign openV[g] = bif[g].isOpen;
      qbs_bank uBank (
        .mclk(mclk),
        .resetn(resetn),
        .bus(bif[g])
      );
    end
  endgenerate
  logic colCmd, lastBeat;
  assign colCmd = (cmd == qbs_pkg::QBS_RD) || (cmd == qbs_pkg::QBS_WR);
  assign lastBeat = r.busy && (r.left == 9'h001) && r.blen != `QBS_FULL_PAGE;
  always_comb begin
    actV = '0;
    preV = '0;
    apV = '0;
    endV = '0;
    if (cmd == qbs_pkg::QBS_ACT && !openV[bankSel]) actV[bankSel] = 1'b1;
    if (cmd == qbs_pkg::QBS_PRE) begin
      if (addr[`QBS_PRE_BIT]) preV = 4'hF;
      else preV[bankSel] = 1'b1;
    end
    if (colCmd && addr[`QBS_PRE_BIT]) apV[bankSel] = 1'b1;
    if (colCmd && openV[bankSel] && burst_count(burst_length) == 9'h001) begin
      endV[bankSel] = 1'b1;
    end
    if (r.busy && (lastBeat || colCmd || cmd == qbs_pkg::QBS_BST)) endV[r.bank] = 1'b1;
  end
  always_comb begin
    next_r = r;
    wrEn = 1'b0;
    wrIdx = {r.bank, r.col};
    next_r.rdV1 = 1'b0;
    next_r.mask1 = byteMask;
    if (r.busy) begin
      if (r.isWrite) wrEn = 1'b1;
      else next_r.rdV1 = 1'b1;
      next_r.col = next_col(r.col, r.blen);
      next_r.left = r.left - 9'h001;
      if (lastBeat) next_r.busy = 1'b0;
    end
    if (cmd == qbs_pkg::QBS_BST) next_r.busy = 1'b0;
    if (colCmd && openV[bankSel]) begin
      wrIdx = {bankSel, addr[7:0]};
      wrEn = (cmd == qbs_pkg::QBS_WR);
      next_r.rdV1 = (cmd == qbs_pkg::QBS_RD);
      next_r.isWrite = (cmd == qbs_pkg::QBS_WR);
      next_r.bank = bankSel;
      next_r.blen = burst_length;
      next_r.col = next_col(addr[7:0], burst_length);
      next_r.left = burst_count(burst_length) - 9'h001;
      next_r.busy = (burst_count(burst_length) != 9'h001);
    end
    next_r.rdD1 = mem[wrIdx];
    next_r.dout = r.rdD1;
    next_r.oe = r.rdV1 ? ~r.mask1 : 4'h0;
  end
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (wrEn && !byteMask[i]) mem[wrIdx][8*i +: 8] <= dqIn[8*i +: 8];
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) r <= '0;
    else r <= next_r;
  end
  assign dqOut = r.dout;
  assign dqOe = r.oe;
  a_mask_hiz: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_RD && openV[bankSel] && byteMask[0]) |-> ##2 !dqOe[0])
    else $error("masked read byte driven");
  a_read_drive: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_RD && openV[bankSel] && !byteMask[0]) |-> ##2 dqOe[0])
    else $error("read byte not driven");
  a_cs_ignore: assert property (@(posedge mclk) disable iff (!resetn)
    (csN && !r.busy) |=> !r.busy)
    else $error("command taken while deselected");
  a_burst_len: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_RD && openV[bankSel] && burst_length == 3'h2 && csN == 1'b0)
    |=> r.busy && r.left == 9'h003)
    else $error("burst length wrong");
  a_col_step: assert property (@(posedge mclk) disable iff (!resetn)
    (r.busy && !colCmd && r.blen == 3'h3) |=> r.col[2:0] == $past(r.col[2:0]) + 3'h1)
    else $error("column not advanced");
  a_start_col: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_WR && openV[bankSel] && burst_length == 3'h1) |=>
    r.col == ($past(addr[7:0]) ^ 8'h01))
    else $error("start column wrong");
  a_term_stop: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_BST) |=> !r.busy)
    else $error("terminate ignored");
  a_pre_all: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd == qbs_pkg::QBS_PRE && addr[`QBS_PRE_BIT]) |=> openV == 4'h0)
    else $error("precharge all left a bank open");
endmodule // quad_bank_sdram_core

// file: verilog/qbs_regs.svh
// timing counts and field positions for the sdram access core
`ifndef QBS_REGS_SVH
`define QBS_REGS_SVH
`define QBS_ROW_W 12
`define QBS_COL_W 8
`define QBS_BANKS 4
`define QBS_PRE_BIT 10
`define QBS_T_RP_NS 20
`define QBS_CLK_NS 40
`define QBS_T_RP_CYC (((`QBS_T_RP_NS + `QBS_CLK_NS - 1) / `QBS_CLK_NS) > 0 ? \
  ((`QBS_T_RP_NS + `QBS_CLK_NS - 1) / `QBS_CLK_NS) : 1)
`define QBS_MASK_LAT 2
`define QBS_FULL_PAGE 3'h7
`endif

// file: verilog/qbs_pkg.sv
// types for the sdram access core
package qbs_pkg;
  typedef enum logic [2:0] {
    QBS_NOP = 3'h0,
    QBS_ACT = 3'h1,
    QBS_RD = 3'h2,
    QBS_WR = 3'h3,
    QBS_PRE = 3'h4,
    QBS_BST = 3'h5,
    QBS_LMR = 3'h6,
    QBS_REF = 3'h7
  } qbs_cmd_e;
  typedef enum logic [1:0] {
    QBS_IDLE = 2'h0,
    QBS_OPEN = 2'h1,
    QBS_PCHG = 2'h3
  } qbs_bank_e;
endpackage

// file: verilog/qbs_bank_if.sv
// per-bank status and command carrier
interface qbs_bank_if;
  logic act;
  logic pre;
  logic autoPre;
  logic burstEnd;
  logic [11:0] row;
  logic isOpen;
  logic [11:0] openRow;
  modport core (output act, pre, autoPre, burstEnd, row, input isOpen, openRow);
  modport bank (input act, pre, autoPre, burstEnd, row, output isOpen, openRow);
endinterface

// file: verilog/qbs_bank.sv
// one bank: open row tracking and self-timed precharge
`include "qbs_regs.svh"
module qbs_bank (
  input wire logic mclk,
  input wire logic resetn,
  qbs_bank_if.bank bus
);
  typedef struct packed {
    qbs_pkg::qbs_bank_e st;
    logic pend;
    logic [1:0] cnt;
    logic [11:0] row;
  } qbs_bst_s;
  qbs_bst_s r, next_r;
  always_comb begin
    next_r = r;
    case (r.st)
      qbs_pkg::QBS_IDLE: begin
        if (bus.act) begin
          next_r.st = qbs_pkg::QBS_OPEN;
          next_r.row = bus.row;
          next_r.pend = 1'b0;
        end
      end
      qbs_pkg::QBS_OPEN: begin
        if (bus.autoPre) next_r.pend = 1'b1;
        if (bus.pre || ((r.pend || bus.autoPre) && bus.burstEnd)) begin
          next_r.st = qbs_pkg::QBS_PCHG;
          next_r.cnt = 2'(`QBS_T_RP_CYC);
          next_r.pend = 1'b0;
        end
      end
      qbs_pkg::QBS_PCHG: begin
        next_r.cnt = r.cnt - 2'h1;
        if (r.cnt <= 2'h1) next_r.st = qbs_pkg::QBS_IDLE;
      end
      default: next_r.st = qbs_pkg::QBS_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) r <= '0;
    else r <= next_r;
  end
  assign bus.isOpen = (r.st == qbs_pkg::QBS_OPEN);
  assign bus.openRow = r.row;
  a_open_row_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (r.st == qbs_pkg::QBS_OPEN && !bus.pre && !bus.burstEnd) |=> r.st == qbs_pkg::QBS_OPEN)
    else $error("open bank closed without precharge");
  a_pchg_ends: assert property (@(posedge mclk) disable iff (!resetn)
    r.st == qbs_pkg::QBS_PCHG |-> ##[1:3] r.st == qbs_pkg::QBS_IDLE)
    else $error("precharge did not finish");
endmodule // qbs_bank

// file: sim/qbs_ctrl_model.sv
// controller-side model driving the sdram core pins
module qbs_ctrl_model (
  input wire logic mclk,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bankSel,
  output logic [11:0] addr,
  output logic [3:0] byteMask,
  output logic [2:0] burst_length,
  output logic [31:0] dqIn,
  input wire logic [31:0] dqOut,
  input wire logic [3:0] dqOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got [0:15];
  logic [3:0] oe [0:15];
  initial begin
    {csN, rasN, casN, weN} = 4'hf;
    bankSel = 2'h0;
    addr = 12'h000;
    byteMask = 4'h0;
    burst_length = 3'h0;
    dqIn = 32'h0000_0000;
  end
  // one command cycle, then nop; caller issues any activate
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic [2:0] bl = 3'h0, input logic [3:0] m = 4'h0,
      input logic [31:0] d = 32'h0000_0000);
    {csN, rasN, casN, weN} = c;
    bankSel = b;
    addr = a;
    burst_length = bl;
    byteMask = m;
    dqIn = d;
    @(posedge mclk);
    #1;
    {csN, rasN, casN, weN} = 4'h7;
    byteMask = 4'h0;
    dqIn = ~dqIn;
  endtask
  task automatic cap(input int k);
    for (int i = 0; i < k; i++) begin
      got[i] = dqOut;
      oe[i] = dqOe;
      @(posedge mclk);
      #1;
    end
  endtask
endmodule // qbs_ctrl_model

// file: sim/tb.sv
// self-checking bench for the sdram access core
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, BST = 4'h6, NOP = 4'h7;
  logic mclk;
  logic resetn;
  logic csN, rasN, casN, weN;
  logic [1:0] bankSel;
  logic [11:0] addr;
  logic [3:0] byteMask, dqOe;
  logic [2:0] burst_length;
  logic [31:0] dqIn, dqOut;
  int errCount = 0;
  int nTests = 0;
  int cyc = 0;
  quad_bank_sdram_core u_dut (.mclk(mclk), .resetn(resetn), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankSel(bankSel), .addr(addr), .byteMask(byteMask),
    .burst_length(burst_length), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  qbs_ctrl_model u_ctl (.mclk(mclk), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .bankSel(bankSel), .addr(addr), .byteMask(byteMask), .burst_length(burst_length),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errCount++;
      stopTest();
    end
  end
  task automatic stopTest;
    $display("errors %0d checks %0d", errCount, nTests);
    if (errCount == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // data compared only where all bytes drive
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    nTests++;
    if (g[35:32] !== e[35:32] || (e[35:32] == 4'hf && g[31:0] !== e[31:0])) begin
      errCount++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [35:0] beat(input int i);
    return {u_ctl.oe[i], u_ctl.got[i]};
  endfunction
  task automatic tWrRd;
    u_ctl.issue(ACT, 2'h0, 12'h005);
    u_ctl.issue(ACT, 2'h1, 12'h009);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 8; i++) begin
        u_ctl.issue(i == 0 ? WR : NOP, 2'(b), 12'h000, 3'h3, 4'h0, (b + 1) * 32'h1000_0000 + i);
      end
    end
    for (int i = 0; i < 4; i++) begin
      u_ctl.issue(i == 0 ? WR : NOP, 2'h0, 12'h006, 3'h2, i == 1 ? 4'h1 : 4'h0, 32'hA0A0_A0A0 + i);
    end
    u_ctl.issue(RD, 2'h0, 12'h004, 3'h3);
    u_ctl.cap(10);
    chk(beat(1), {4'hf, 32'hA0A0_A0A2});
    chk(beat(2), {4'hf, 32'hA0A0_A0A3});
    chk(beat(3), {4'hf, 32'hA0A0_A0A0});
    chk(beat(4), {4'hf, 32'hA0A0_A007});
    for (int k = 5; k < 9; k++) chk(beat(k), {4'hf, 32'h1000_0000 + k - 5});
    for (int c = 0; c < 4; c++) begin
      u_ctl.issue(RD, 2'h1, 12'h000, 3'(c), 4'h8);
      u_ctl.cap(10);
      chk(beat(1), {4'h7, 32'h0000_0000});
      chk(beat((1 << c) + 1), {4'h0, 32'h0000_0000});
      if (c > 0) chk(beat(1 << c), {4'hf, 32'h2000_0000 + (1 << c) - 1});
    end
  endtask
  task automatic tCsBreak;
    u_ctl.issue(4'hc, 2'h0, 12'h000, 3'h0, 4'h0, 32'hDEAD_BEEF);
    u_ctl.issue(RD, 2'h0, 12'h000, 3'h3);
    u_ctl.issue(RD, 2'h0, 12'h003);
    u_ctl.cap(4);
    chk(beat(0), {4'hf, 32'h1000_0000});
    chk(beat(1), {4'hf, 32'h1000_0003});
    chk(beat(2), {4'h0, 32'h0000_0000});
    u_ctl.issue(RD, 2'h1, 12'h000, 3'h3);
    u_ctl.issue(NOP, 2'h1, 12'h000);
    u_ctl.issue(BST, 2'h1, 12'h000);
    u_ctl.cap(4);
    chk(beat(3), {4'h0, 32'h0000_0000});
    u_ctl.issue(WR, 2'h1, 12'h009, 3'h1, 4'h0, 32'h3000_0009);
    u_ctl.issue(NOP, 2'h1, 12'h000, 3'h1, 4'h0, 32'h3000_0008);
    u_ctl.issue(RD, 2'h1, 12'h008, 3'h7);
    u_ctl.issue(NOP, 2'h1, 12'h000);
    u_ctl.issue(BST, 2'h1, 12'h000);
    u_ctl.cap(3);
    chk(beat(0), {4'hf, 32'h3000_0009});
    chk(beat(2), {4'h0, 32'h0000_0000});
  endtask
  task automatic tBanks;
    u_ctl.issue(RD, 2'h1, 12'h000, 3'h3);
    u_ctl.issue(PRE, 2'h0, 12'h000);
    u_ctl.issue(RD, 2'h0, 12'h001);
    u_ctl.cap(8);
    for (int k = 0; k < 7; k++) chk(beat(k), {4'hf, 32'h2000_0001 + k});
    chk(beat(7), {4'h0, 32'h0000_0000});
    u_ctl.issue(4'h1, 2'h0, 12'h000);
    u_ctl.issue(ACT, 2'h0, 12'h005);
    u_ctl.issue(RD, 2'h0, 12'h401);
    u_ctl.cap(4);
    chk(beat(1), {4'hf, 32'h1000_0001});
    u_ctl.issue(RD, 2'h0, 12'h002);
    u_ctl.cap(3);
    chk(beat(1), {4'h0, 32'h0000_0000});
    u_ctl.issue(PRE, 2'h0, 12'h400);
    u_ctl.issue(RD, 2'h1, 12'h000);
    u_ctl.cap(3);
    chk(beat(1), {4'h0, 32'h0000_0000});
  endtask
  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    tWrRd();
    tCsBreak();
    tBanks();
    stopTest();
  end
endmodule // tb
